// File: design/avsw_pkg.sv
// Purpose: shared constants and types for the a/v switch two-wire link
// Assumes: 100 MHz core clock; the controller end makes the serial clock
// Notes:   bit numbers count from 0; the control byte is sent msb first
//
// Operation
// [R1] sda falling while scl high starts transfer
// [R2] sda rising while scl high ends transfer
// [R3] eight bits per byte, clocked by scl
// [R4] bytes travel most significant bit first
// [R5] device holds sda low during ninth clock
// [R6] first byte is address 92h, device-only match
// [R7] controller always sends direction bit low
// [R8] start, address, ack, data, ack, stop
// [R9] stop before eighth bit discards partial byte
// [R10] settings start in defined protective state
// [R11] control byte fields and initial values
// [R12] wrong address: no ack, ignore until start
// [R13] settings update after acknowledged eighth bit
package avsw_pkg;

    // addressing: 7-bit address followed by the write direction bit
    localparam logic [7:0] AVSW_ADDR_BYTE      = 8'h92;
    localparam logic [3:0] AVSW_BITS_PER_BYTE  = 4'h8;
    localparam logic [3:0] AVSW_ACK_SLOT       = 4'h8;

    // control byte field positions (bit 0 is the first-listed field)
    localparam int         AVSW_SEL_LSB        = 0;
    localparam int         AVSW_MUTE_BIT       = 2;
    localparam int         AVSW_LVL_LSB        = 3;
    localparam int         AVSW_ALC_OFF_BIT    = 5;
    localparam int         AVSW_FIX1_BIT       = 6;
    localparam int         AVSW_FIX0_BIT       = 7;

    // initial settings and field codes
    localparam logic [1:0] AVSW_TUNER_INPUT_SELECT = 2'h0;
    localparam logic [1:0] AVSW_SEL_INIT       = AVSW_TUNER_INPUT_SELECT;
    localparam logic       AVSW_MUTE_INIT      = 1'b0;
    localparam logic [1:0] AVSW_LVL_INIT       = 2'h2;
    localparam logic       AVSW_ALC_OFF_INIT   = 1'b0;

    // controller register map (apb, one word each)
    localparam logic [7:0] AVSW_REG_DATA       = 8'h00;
    localparam logic [7:0] AVSW_REG_CMD        = 8'h04;
    localparam logic [7:0] AVSW_REG_STAT       = 8'h08;
    localparam int         AVSW_CMD_GO_BIT     = 0;
    localparam int         AVSW_ST_BUSY_BIT    = 0;
    localparam int         AVSW_ST_ANACK_BIT   = 1;
    localparam int         AVSW_ST_DNACK_BIT   = 2;
    localparam int         AVSW_ST_DONE_BIT    = 3;

    // serial clock timing: four equal quarters per bit
    localparam int         AVSW_CORE_PERIOD_NS = 10;
    localparam int         AVSW_SCL_PERIOD_NS  = 10000;
    localparam int         AVSW_QUARTER_CYC    =
        (AVSW_SCL_PERIOD_NS + 4 * AVSW_CORE_PERIOD_NS - 1)
        / (4 * AVSW_CORE_PERIOD_NS);
    localparam logic [8:0] AVSW_QUARTER_LAST   = 9'(AVSW_QUARTER_CYC - 1);

    typedef enum logic [1:0] {C_IDLE, C_START, C_BIT, C_STOP} avsw_cst_t;
    typedef enum logic [2:0] {
        D_IDLE, D_ADDR, D_ADDR_ACK, D_DATA, D_DATA_ACK, D_IGNORE
    } avsw_dst_t;

endpackage

// File: design/avsw_if.sv
// Purpose: two-wire link between controller and switch device
// Assumes: sda is open drain; scl is driven only by the controller
// Notes:   the wire level is resolved here from both ends' enables
`timescale 1ns/1ps
interface avsw_if;
    logic serial_clock_pin;
    logic serial_data_pin;
    logic ctrl_sda_o;
    logic ctrl_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;

    // pulled-up wire: low when any enabled driver drives low
    assign serial_data_pin = ~((ctrl_sda_oe & ~ctrl_sda_o) |
                               (dev_sda_oe & ~dev_sda_o));

    modport ctrl (
        output serial_clock_pin,
        output ctrl_sda_o,
        output ctrl_sda_oe,
        input  serial_data_pin
    );
    modport dev (
        input  serial_clock_pin,
        input  serial_data_pin,
        output dev_sda_o,
        output dev_sda_oe
    );
endinterface

// File: design/avsw_dev.sv
// Purpose: write-only serial slave holding the switch control settings
// Assumes: LINK_CLK oversamples scl at several times its rate
// Notes:   a byte with bad fixed bits is acknowledged but not applied
`timescale 1ns/1ps
module avsw_dev
    import avsw_pkg::*;
(
    // clock and reset
    input  wire logic       LINK_CLK,
    input  wire logic       RESETN,
    // serial link
    avsw_if.dev             LINK,
    // control settings
    output logic [1:0]      INPUT_SELECT,
    output logic            MUTE,
    output logic [1:0]      AUTOMATIC_LEVEL_CONTROL_LEVEL,
    output logic            AUTOMATIC_LEVEL_CONTROL_OFF,
    output logic            UPDATE
);
    logic       scl_s1_q, scl_s2_q, scl_s3_q;
    logic       sda_s1_q, sda_s2_q, sda_s3_q;
    logic       start_c, stop_c, rise_c, fall_c;
    avsw_dst_t  state_q;
    logic [3:0] cnt_q;
    logic [7:0] shift_q;
    logic       fix_ok;

    // two-flop synchronisers, then one stage for edge detection
    always_ff @(posedge LINK_CLK or negedge RESETN) begin
        if (!RESETN) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end else begin
            scl_s1_q <= LINK.serial_clock_pin;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= LINK.serial_data_pin;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    // bus conditions seen on the synchronised lines
    assign start_c = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q; // [R1]
    assign stop_c  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q; // [R2]
    assign rise_c  = scl_s2_q & ~scl_s3_q;
    assign fall_c  = ~scl_s2_q & scl_s3_q;
    assign fix_ok  = shift_q[AVSW_FIX1_BIT] & ~shift_q[AVSW_FIX0_BIT];

    // receive sequencer; start restarts from any state, even mid-byte
    always_ff @(posedge LINK_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= D_IDLE;
            cnt_q   <= 4'h0;
            shift_q <= 8'h00;
        end else if (start_c) begin
            state_q <= D_ADDR;                                 // [R1]
            cnt_q   <= 4'h0;
        end else if (stop_c) begin
            state_q <= D_IDLE;                          // [R2] [R9]
        end else begin
            case (state_q)
                D_ADDR, D_DATA: begin
                    if (rise_c && cnt_q < AVSW_BITS_PER_BYTE) begin
                        shift_q <= {shift_q[6:0], sda_s2_q}; // [R3] [R4]
                        cnt_q   <= cnt_q + 4'h1;
                    end else if (fall_c && cnt_q == AVSW_BITS_PER_BYTE) begin
                        if (state_q == D_DATA)
                            state_q <= D_DATA_ACK;             // [R8]
                        else if (shift_q == AVSW_ADDR_BYTE)
                            state_q <= D_ADDR_ACK;             // [R6]
                        else
                            state_q <= D_IGNORE;              // [R12]
                    end
                end
                D_ADDR_ACK: begin
                    if (fall_c) begin
                        state_q <= D_DATA;                     // [R8]
                        cnt_q   <= 4'h0;
                    end
                end
                D_DATA_ACK: begin
                    // one control byte per write; further bytes unanswered
                    if (fall_c)
                        state_q <= D_IGNORE;
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    // acknowledge: pull sda low from the eighth fall to the ninth fall
    assign LINK.dev_sda_o  = 1'b0;
    assign LINK.dev_sda_oe = (state_q == D_ADDR_ACK) ||
                             (state_q == D_DATA_ACK);          // [R5]

    // settings change together, only when the whole byte was acked
    always_ff @(posedge LINK_CLK or negedge RESETN) begin
        if (!RESETN) begin
            INPUT_SELECT                  <= AVSW_SEL_INIT;    // [R10]
            MUTE                          <= AVSW_MUTE_INIT;
            AUTOMATIC_LEVEL_CONTROL_LEVEL <= AVSW_LVL_INIT;
            AUTOMATIC_LEVEL_CONTROL_OFF   <= AVSW_ALC_OFF_INIT;
            UPDATE                        <= 1'b0;
        end else begin
            UPDATE <= 1'b0;
            if (state_q == D_DATA_ACK && fall_c && !start_c && !stop_c
                && fix_ok) begin                         // [R9] [R13]
                INPUT_SELECT  <= shift_q[AVSW_SEL_LSB +: 2];   // [R11]
                MUTE          <= shift_q[AVSW_MUTE_BIT];
                AUTOMATIC_LEVEL_CONTROL_LEVEL <= shift_q[AVSW_LVL_LSB +: 2];
                AUTOMATIC_LEVEL_CONTROL_OFF   <= shift_q[AVSW_ALC_OFF_BIT];
                UPDATE        <= 1'b1;
            end
        end
    end
endmodule

// File: design/avsw_ctrl.sv
// Purpose: apb-programmed controller that writes one control byte
// Assumes: scl made here by dividing CORE_CLK; no clock stretching
// Notes:   zero wait state apb slave; go is ignored while busy
`timescale 1ns/1ps
module avsw_ctrl
    import avsw_pkg::*;
(
    // clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RESETN,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // serial link
    avsw_if.ctrl             LINK
);
    avsw_cst_t  state_q;
    logic [8:0] qcnt_q;
    logic [1:0] ph_q;
    logic [3:0] bitn_q;
    logic       byte1_q;
    logic [7:0] shift_q;
    logic [7:0] data_q;
    logic       anack_q, dnack_q, done_q;
    logic       scl_q, sda_q;
    logic       sda_s1_q, sda_s2_q;
    logic       tick, last_q, access, wr, go, mapped;

    // apb decode; every access completes in its first access cycle
    assign access  = PSEL & PENABLE;
    assign wr      = access & PWRITE;
    assign mapped  = (PADDR == AVSW_REG_DATA) || (PADDR == AVSW_REG_CMD) ||
                     (PADDR == AVSW_REG_STAT);
    assign PREADY  = 1'b1;
    assign PSLVERR = access & ~mapped;
    // go counts only when idle, so a late write can never cut a frame
    assign go      = wr && PADDR == AVSW_REG_CMD &&
                     PWDATA[AVSW_CMD_GO_BIT] && state_q == C_IDLE;
    assign tick    = (qcnt_q == AVSW_QUARTER_LAST);
    assign last_q  = (ph_q == 2'h3);

    // read data is registered in the setup cycle
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            PRDATA <= 32'h0;
        end else if (PSEL && !PENABLE) begin
            if (PADDR == AVSW_REG_DATA)
                PRDATA <= {24'h0, data_q};
            else if (PADDR == AVSW_REG_STAT)
                PRDATA <= {28'h0, done_q, dnack_q, anack_q,
                           state_q != C_IDLE};
            else
                PRDATA <= 32'h0;
        end
    end

    // control byte to send
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN)
            data_q <= {AVSW_FIX0_INIT(), AVSW_FIX1_INIT(), 6'h0};
        else if (wr && PADDR == AVSW_REG_DATA)
            data_q <= PWDATA[7:0];
    end

    // sda from the link is sampled through two flops
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end else begin
            sda_s1_q <= LINK.serial_data_pin;
            sda_s2_q <= sda_s1_q;
        end
    end

    // quarter-bit divider, restarted on go
    // idle holds it at zero, so a frame always opens on a whole quarter
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN)
            qcnt_q <= 9'h0;
        else if (state_q == C_IDLE || tick)
            qcnt_q <= 9'h0;
        else
            qcnt_q <= qcnt_q + 9'h1;
    end

    // transfer sequencer: start, two bytes each with ack slot (one if the address is nacked), stop
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= C_IDLE;
            ph_q    <= 2'h0;
            bitn_q  <= 4'h0;
            byte1_q <= 1'b0;
            shift_q <= 8'h0;
        end else if (go) begin
            state_q <= C_START;                                // [R1]
            ph_q    <= 2'h0;
            byte1_q <= 1'b0;
            shift_q <= AVSW_ADDR_BYTE;                    // [R6] [R7]
        end else if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (state_q)
                C_START: begin
                    if (last_q) begin
                        state_q <= C_BIT;
                        bitn_q  <= 4'h0;
                    end
                end
                C_BIT: begin
                    if (last_q && bitn_q < AVSW_ACK_SLOT) begin
                        shift_q <= {shift_q[6:0], 1'b0};         // [R4]
                        bitn_q  <= bitn_q + 4'h1;
                    end else if (last_q) begin
                        if (sda_s2_q || byte1_q) begin
                            state_q <= C_STOP;            // [R2] [R8]
                        end else begin
                            byte1_q <= 1'b1;                   // [R8]
                            bitn_q  <= 4'h0;
                            shift_q <= data_q;
                        end
                    end
                end
                C_STOP: begin
                    if (last_q)
                        state_q <= C_IDLE;
                end
                default: begin
                    state_q <= C_IDLE;
                end
            endcase
        end
    end

    // status flags: cleared by a new go; nack flags set at the ack slot, done at the end of stop
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            anack_q <= 1'b0;
            dnack_q <= 1'b0;
            done_q  <= 1'b0;
        end else if (go) begin
            anack_q <= 1'b0;
            dnack_q <= 1'b0;
            done_q  <= 1'b0;
        end else if (tick && last_q) begin
            if (state_q == C_BIT && bitn_q == AVSW_ACK_SLOT && sda_s2_q) begin
                anack_q <= ~byte1_q;
                dnack_q <= byte1_q;
            end
            if (state_q == C_STOP)
                done_q <= 1'b1;
        end
    end

    // pin levels per quarter: bit and stop slots have scl high in quarters 2-3; data sda changes in
    // quarter 1 so it never moves near an scl edge
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            case (state_q)
                C_START: begin
                    scl_q <= (ph_q != 2'h3);
                    sda_q <= (ph_q == 2'h0);                   // [R1]
                end
                C_BIT: begin
                    scl_q <= ph_q[1];                          // [R3]
                    if (ph_q == 2'h1)
                        sda_q <= (bitn_q == AVSW_ACK_SLOT) ? 1'b1
                                                           : shift_q[7];
                end
                C_STOP: begin
                    scl_q <= ph_q[1];
                    if (ph_q == 2'h1)
                        sda_q <= 1'b0;
                    else if (ph_q == 2'h3)
                        sda_q <= 1'b1;                         // [R2]
                end
                default: begin
                    scl_q <= 1'b1;
                    sda_q <= 1'b1;
                end
            endcase
        end
    end

    // open drain: enable only while pulling low
    assign LINK.serial_clock_pin = scl_q;
    assign LINK.ctrl_sda_o       = 1'b0;
    assign LINK.ctrl_sda_oe      = ~sda_q;

    // fixed top bit of the power-up control byte: must stay low
    function automatic logic AVSW_FIX0_INIT();
        return 1'b0;
    endfunction

    // fixed second bit of the power-up control byte: must stay high
    function automatic logic AVSW_FIX1_INIT();
        return 1'b1;
    endfunction
endmodule

// File: bench/avsw_props.sv
// Purpose: concurrent checks on the link joining controller and device
// Assumes: controller quarter of 250 core cycles; link clock oversamples
// Notes:   both ends are design code, so every check here binds a design
`timescale 1ns/1ps
module avsw_props
    import avsw_pkg::*;
(
    // clocks and reset
    input wire logic CORE_CLK,
    input wire logic LINK_CLK,
    input wire logic RESETN,
    // link wires and enables
    input wire logic serial_clock_pin,
    input wire logic serial_data_pin,
    input wire logic ctrl_sda_oe,
    input wire logic dev_sda_oe
);
    logic       scl_q;
    logic       sda_q;
    logic [4:0] rise_q;

    // scl rises since the last start; the count tells the bit slot
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            scl_q  <= 1'b1;
            sda_q  <= 1'b1;
            rise_q <= 5'h0;
        end else begin
            scl_q <= serial_clock_pin;
            sda_q <= serial_data_pin;
            if (scl_q && serial_clock_pin && sda_q && !serial_data_pin)
                rise_q <= 5'h0;
            else if (!scl_q && serial_clock_pin)
                rise_q <= rise_q + 5'h1;
        end
    end

    // device holds the wire low and the controller keeps off it
    sequence ack_held;
        (!serial_data_pin && dev_sda_oe && !ctrl_sda_oe) [*8];
    endsequence
    sequence scl_high_run;
        serial_clock_pin [*8];
    endsequence

    AST_START_FORM: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        $rose(ctrl_sda_oe) && serial_clock_pin |->
        scl_high_run ##[1:600] !serial_clock_pin)
        else $error("start not followed by a clock pulse");
    AST_STOP_FORM: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        $fell(ctrl_sda_oe) && serial_clock_pin |->
        $past(serial_clock_pin, 200) && serial_data_pin ##1 scl_high_run)
        else $error("stop did not leave the bus idle");
    AST_DATA_STABLE: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        $changed(ctrl_sda_oe) && serial_clock_pin |->
        $past(serial_clock_pin, 240))
        else $error("data moved while scl high");
    AST_SCL_LOW_BOUND: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        $fell(serial_clock_pin) |->
        !serial_clock_pin [*8] ##[1:800] serial_clock_pin)
        else $error("scl low phase out of range");
    AST_ADDR_MSB_FIRST: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        $rose(serial_clock_pin) && rise_q < 5'h8 |->
        serial_data_pin == AVSW_ADDR_BYTE[3'h7 - rise_q[2:0]])
        else $error("address bit wrong");
    AST_ACK_HELD: assert property (
        @(posedge CORE_CLK) disable iff (!RESETN)
        $rose(serial_clock_pin) && (rise_q == 5'h8 || rise_q == 5'h11)
        |-> ack_held)
        else $error("ack slot not held low");
    AST_DEV_MOVES_LOW: assert property (
        @(posedge LINK_CLK) disable iff (!RESETN)
        $changed(dev_sda_oe) |->
        !serial_clock_pin && !$past(serial_clock_pin))
        else $error("device moved sda while scl high");
    AST_ACK_RELEASE: assert property (
        @(posedge LINK_CLK) disable iff (!RESETN)
        $fell(serial_clock_pin) && dev_sda_oe |-> ##[1:8] !dev_sda_oe)
        else $error("device kept sda after ack slot");
endmodule

// File: bench/av_switch_i2c_write_slave_tb_top.sv
// Purpose: apb run through the controller, fault traffic on a second link
// Assumes: bench quarter of 20 core cycles on the second link
// Notes:   only the second link can carry a wrong address or a cut byte
`timescale 1ns/1ps
module av_switch_i2c_write_slave_tb_top
    import avsw_pkg::*;
;
    localparam int QB   = 20;
    localparam int CEIL = 60000;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [5:0] s;  // select, mute, level, level control off
        logic       aa;
        logic       da;
    } avsw_row_t;
    logic        core_clk, link_clk, resetn;
    logic        psel, penable, pwrite, pslverr, pready, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  sel1, lvl1, sel2, lvl2;
    logic        mute1, off1, upd1, mute2, off2, upd2;
    logic [5:0]  set1, set2;
    int          fail_count, checks_done, cycles, upd_cnt, upd1_cnt;
    avsw_row_t   rows [6] = '{
        '{8'h92, 8'h41, 6'h10, 1'b1, 1'b1},
        '{8'h92, 8'h52, 6'h24, 1'b1, 1'b1},
        '{8'h92, 8'h6f, 6'h3b, 1'b1, 1'b1},
        '{8'h92, 8'h58, 6'h06, 1'b1, 1'b1},
        '{8'h93, 8'h41, 6'h06, 1'b0, 1'b0},   // read bit: ignored
        '{8'h92, 8'hc1, 6'h06, 1'b1, 1'b1}};  // top fixed bit wrong

    avsw_if lk1 ();
    avsw_if lk2 ();
    assign set1 = {sel1, mute1, lvl1, off1};
    assign set2 = {sel2, mute2, lvl2, off2};

    avsw_ctrl avsw_ctrl_i (.CORE_CLK(core_clk), .RESETN(resetn),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .LINK(lk1));
    avsw_dev avsw_dev_i (.LINK_CLK(link_clk), .RESETN(resetn), .LINK(lk1),
        .INPUT_SELECT(sel1), .MUTE(mute1),
        .AUTOMATIC_LEVEL_CONTROL_LEVEL(lvl1),
        .AUTOMATIC_LEVEL_CONTROL_OFF(off1), .UPDATE(upd1));
    avsw_dev avsw_dev_i2 (.LINK_CLK(link_clk), .RESETN(resetn), .LINK(lk2),
        .INPUT_SELECT(sel2), .MUTE(mute2),
        .AUTOMATIC_LEVEL_CONTROL_LEVEL(lvl2),
        .AUTOMATIC_LEVEL_CONTROL_OFF(off2), .UPDATE(upd2));
    avsw_props avsw_props_i (.CORE_CLK(core_clk), .LINK_CLK(link_clk),
        .RESETN(resetn), .serial_clock_pin(lk1.serial_clock_pin),
        .serial_data_pin(lk1.serial_data_pin),
        .ctrl_sda_oe(lk1.ctrl_sda_oe), .dev_sda_oe(lk1.dev_sda_oe));

    // core clock
    always #5 core_clk = ~core_clk;
    // link clock, offset so its edges never meet the core's
    initial begin
        link_clk = 1'b0;
        #3.7;
        forever #15 link_clk = ~link_clk;
    end
    // hang guard and counts of settings loads on both devices
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == CEIL) begin
            fail_count++;
            report_and_stop();
        end
    end
    always @(posedge link_clk) if (upd2 === 1'b1) upd_cnt++;
    always @(posedge link_clk) if (upd1 === 1'b1) upd1_cnt++;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one apb transfer; waits an edge first so psel is never set twice
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic q();
        repeat (QB) @(posedge core_clk);
    endtask
    // one bit slot on the second link: sda moves only while scl is low
    task automatic slot(input logic b, output logic seen);
        lk2.serial_clock_pin <= 1'b0;
        q();
        lk2.ctrl_sda_oe <= ~b;
        q();
        lk2.serial_clock_pin <= 1'b1;
        q();
        seen = lk2.serial_data_pin;
        q();
    endtask
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) slot(v[i], s);
        slot(1'b1, s);
        ack = ~s;
    endtask
    task automatic start_cond();
        q();
        lk2.ctrl_sda_oe <= 1'b1;
        q();
    endtask
    task automatic stop_cond();
        lk2.serial_clock_pin <= 1'b0;
        q();
        lk2.ctrl_sda_oe <= 1'b1;
        q();
        lk2.serial_clock_pin <= 1'b1;
        q();
        lk2.ctrl_sda_oe <= 1'b0;
        q();
    endtask

    // main sequence
    initial begin
        logic a, b;
        core_clk = 1'b0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        lk2.serial_clock_pin = 1'b1;
        lk2.ctrl_sda_o = 1'b0;
        lk2.ctrl_sda_oe = 1'b0;
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (12) @(posedge core_clk);
        check(32'(set1), 32'h04);
        check(32'(set2), 32'h04);
        foreach (rows[i]) begin
            start_cond();
            put_byte(rows[i].a, a);
            put_byte(rows[i].d, b);
            stop_cond();
            check(32'({a, b}), 32'({rows[i].aa, rows[i].da}));
            check(32'(set2), 32'(rows[i].s));
        end
        // data byte cut short by a stop
        start_cond();
        put_byte(8'h92, a);
        for (int i = 0; i < 4; i++) slot(i[0], b);
        stop_cond();
        check(32'(set2), 32'h06);
        check(32'(a), 32'h1);
        check(32'(upd_cnt), 32'h4);
        // controller path over apb, data register read first, then an unmapped address
        apb(1'b0, AVSW_REG_DATA, 32'h0);
        check(rd, 32'h40);
        apb(1'b0, 8'h0c, 32'h0);
        check(rd, 32'h0);
        check(32'(er), 32'h1);
        apb(1'b1, AVSW_REG_DATA, 32'h1234_567f);
        apb(1'b0, AVSW_REG_DATA, 32'h0);
        check(rd, 32'h7f);
        apb(1'b1, AVSW_REG_CMD, 32'h1);
        apb(1'b0, AVSW_REG_STAT, 32'h0);
        check(32'(rd[0]), 32'h1);
        while (rd[0] !== 1'b0) begin
            repeat (200) @(posedge core_clk);
            apb(1'b0, AVSW_REG_STAT, 32'h0);
        end
        check(rd, 32'h8);
        check(32'(set1), 32'h3f);
        check(32'(upd1_cnt), 32'h1);
        // mid-run reset puts both ends back to their power-up settings
        resetn <= 1'b0;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (12) @(posedge core_clk);
        check(32'(set1), 32'h04);
        check(32'(set2), 32'h04);
        apb(1'b0, AVSW_REG_STAT, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, AVSW_REG_DATA, 32'h0);
        check(rd, 32'h40);
        report_and_stop();
    end
endmodule
